// >>> rtl/spg_consts.svh
// Purpose: Constants for the set-point profile generator
// Assumes: 250 MHz pclk
// Notes:   APB byte offsets and timing counts
`ifndef SPG_CONSTS_SVH
`define SPG_CONSTS_SVH
`define SPG_CLK_HZ        250000000
`define SPG_TICK_MS       100
`define SPG_TICK_CYC      ((`SPG_CLK_HZ / 1000) * `SPG_TICK_MS)
`define SPG_TICKS_SEC     10
`define SPG_TICKS_MIN     600
`define SPG_TICKS_HOUR    36000
`define SPG_A_SEL         12'h000
`define SPG_A_CTRL        12'h004
`define SPG_A_IDLE        12'h008
`define SPG_A_LOOP        12'h00c
`define SPG_A_SEG         12'h010
`define SPG_A_CALM        12'h014
`define SPG_A_CALW        12'h018
`define SPG_A_CALD        12'h01c
`define SPG_A_CALH        12'h020
`define SPG_A_CALS        12'h024
`define SPG_A_CALN        12'h028
`define SPG_A_STAT        12'h02c
`define SPG_A_OUT         12'h030
`define SPG_A_SEGW        12'h034
`define SPG_A_RUN         12'h038
`define SPG_A_LVL         12'h03c
`endif

// >>> rtl/spg_pkg.sv
// Purpose: Types for the set-point profile generator
// Assumes: None
// Notes:   Mode encodings in enums
package spg_pkg;
  typedef enum logic [2:0] {SPG_OFF, SPG_GATE, SPG_ONCE, SPG_RESTART, SPG_CAL} spg_mode_t;
  typedef enum logic [1:0] {SPG_UNIT_S, SPG_UNIT_M, SPG_UNIT_H} spg_unit_t;
  typedef enum logic [1:0] {SPG_LOOP_ONCE, SPG_LOOP_COUNT, SPG_LOOP_INF} spg_loop_t;
  typedef struct packed {
    logic [15:0] dur;
    spg_unit_t   unit;
    logic        slope;
    logic [15:0] endv;
  } spg_seg_t;
  typedef struct packed {
    logic [5:0] sec;
    logic [5:0] min;
    logic [4:0] hour;
    logic [2:0] wday;
    logic [4:0] day;
    logic [3:0] mon;
    logic       sec_pulse;
  } spg_cal_t;
endpackage

// >>> rtl/spg_top.sv
// Purpose: Eight set-point profile generators behind APB
// Assumes: Trigger sources signed, synchronous to pclk; calendar synchronous
// Notes:   Output levels are 16-bit signed
// Behaviour
// - Eight independent instances, any output selectable
// - Five trigger modes; disabled produces nothing
// - Gate mode runs while source above zero
// - Single-shot edge starts, runs to completion
// - Restartable edge restarts from first segment
// - Calendar mode starts on configured times
// - Empty calendar field never starts
// - Calendar start runs to completion
// - Rest level before and after profile
// - Duration unit seconds, minutes or hours
// - Segment shape constant or slope
// - Segment ends at its end level
// - Repeat once, counted or forever
// - Repeats resume at configured segment
// - Slope repeat ramps over whole duration
// - Constant repeat moves within 0.1 s
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "spg_consts.svh"
module spg_top #(
  parameter int NPROF   = 8,
  parameter int NSEG    = 16,
  parameter int TICK_CYC = `SPG_TICK_CYC
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [NPROF*16-1:0]     trig_src,
  input  wire spg_pkg::spg_cal_t       cal,
  output logic      [NPROF*16-1:0]     level_out,
  output logic      [NPROF-1:0]        running
);
  localparam int SW = $clog2(NSEG);
  localparam int PW = $clog2(NPROF);

  // Shared configuration window, selected by the index register
  logic [PW-1:0] sel_q;
  logic [SW-1:0] segi_q;
  spg_pkg::spg_mode_t mode_q [NPROF];
  spg_pkg::spg_loop_t loopm_q [NPROF];
  logic [15:0] idle_q [NPROF];
  logic [15:0] lcnt_q [NPROF];
  logic [SW-1:0] ret_q [NPROF];
  logic [SW-1:0] nseg_q [NPROF];
  spg_pkg::spg_seg_t seg_q [NPROF][NSEG];
  logic [11:0] cm_q [NPROF];
  logic [6:0]  cw_q [NPROF];
  logic [30:0] cd_q [NPROF];
  logic [23:0] ch_q [NPROF];
  logic [59:0] cs_q [NPROF];
  logic [59:0] cn_q [NPROF];
  logic [15:0] lvl_q [NPROF];
  logic [NPROF-1:0] run_q;
  logic [NPROF-1:0] tick_en;

  wire wr     = psel && penable && pwrite;
  wire setup  = psel && !penable;
  // Read data moves only on a read setup
  wire rd_acc = setup && !pwrite;

  // Shared 0.1 s tick
  logic [31:0] div_q;
  logic        tick_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_q  <= 32'h0;
      tick_q <= 1'b0;
    end
    else if (div_q == 32'(TICK_CYC - 1))
    begin
      div_q  <= 32'h0;
      tick_q <= 1'b1;
    end
    else
    begin
      div_q  <= div_q + 32'h1;
      tick_q <= 1'b0;
    end
  end

  function automatic logic [31:0] unit_ticks(input spg_pkg::spg_unit_t u);
    unique case (u)
      spg_pkg::SPG_UNIT_S: unit_ticks = `SPG_TICKS_SEC;
      spg_pkg::SPG_UNIT_M: unit_ticks = `SPG_TICKS_MIN;
      spg_pkg::SPG_UNIT_H: unit_ticks = `SPG_TICKS_HOUR;
      default:             unit_ticks = `SPG_TICKS_SEC;
    endcase
  endfunction

  // Field outside its mask reads as no match
  function automatic logic mask_hit(input logic [59:0] mask, input logic [5:0] idx);
    mask_hit = (idx < 6'h3c) ? mask[idx] : 1'b0;
  endfunction

  // APB register writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_q  <= '0;
      segi_q <= '0;
      for (int p = 0; p < NPROF; p++)
      begin
        mode_q[p]  <= spg_pkg::SPG_OFF;
        loopm_q[p] <= spg_pkg::SPG_LOOP_ONCE;
        idle_q[p]  <= 16'h0;
        lcnt_q[p]  <= 16'h1;
        ret_q[p]   <= '0;
        nseg_q[p]  <= '0;
        cm_q[p] <= '0;
        cw_q[p] <= '0;
        cd_q[p] <= '0;
        ch_q[p] <= '0;
        cs_q[p] <= '0;
        cn_q[p] <= '0;
        for (int s = 0; s < NSEG; s++)
          seg_q[p][s] <= '0;
      end
    end
    else if (wr)
    begin
      unique case (paddr)
        `SPG_A_SEL:
        begin
          sel_q  <= pwdata[PW-1:0];
          segi_q <= pwdata[8+SW-1:8];
        end
        `SPG_A_CTRL:
        begin
          mode_q[sel_q]  <= spg_pkg::spg_mode_t'(pwdata[2:0]);
          loopm_q[sel_q] <= spg_pkg::spg_loop_t'(pwdata[5:4]);
          nseg_q[sel_q]  <= pwdata[8+SW-1:8];
          ret_q[sel_q]   <= pwdata[16+SW-1:16];
        end
        `SPG_A_IDLE: idle_q[sel_q] <= pwdata[15:0];
        `SPG_A_LOOP: lcnt_q[sel_q] <= pwdata[15:0];
        `SPG_A_SEG:
        begin
          seg_q[sel_q][segi_q].dur  <= pwdata[15:0];
          seg_q[sel_q][segi_q].unit <= spg_pkg::spg_unit_t'(pwdata[17:16]);
          seg_q[sel_q][segi_q].slope <= pwdata[20];
        end
        `SPG_A_SEGW: seg_q[sel_q][segi_q].endv <= pwdata[15:0];
        `SPG_A_CALM: cm_q[sel_q] <= pwdata[11:0];
        `SPG_A_CALW: cw_q[sel_q] <= pwdata[6:0];
        `SPG_A_CALD: cd_q[sel_q] <= pwdata[30:0];
        `SPG_A_CALH: ch_q[sel_q] <= pwdata[23:0];
        `SPG_A_CALS: cs_q[sel_q][31:0] <= pwdata;
        `SPG_A_CALN: cs_q[sel_q][59:32] <= pwdata[27:0];
        `SPG_A_STAT: cn_q[sel_q][31:0] <= pwdata;
        `SPG_A_OUT:  cn_q[sel_q][59:32] <= pwdata[27:0];
        default: ;
      endcase
    end
  end

  // APB read and answer: one wait-free access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= 1'b0;
      if (rd_acc)
      begin
        unique case (paddr)
          `SPG_A_SEL:  prdata <= {16'h0, 8'(segi_q), 8'(sel_q)};
          `SPG_A_CTRL: prdata <= {8'h0, 8'(ret_q[sel_q]), 8'(nseg_q[sel_q]),
                                  2'h0, loopm_q[sel_q], 1'b0, mode_q[sel_q]};
          `SPG_A_IDLE: prdata <= {16'h0, idle_q[sel_q]};
          `SPG_A_LOOP: prdata <= {16'h0, lcnt_q[sel_q]};
          `SPG_A_SEG:  prdata <= {11'h0, seg_q[sel_q][segi_q].slope, 2'h0,
                                  seg_q[sel_q][segi_q].unit, seg_q[sel_q][segi_q].dur};
          `SPG_A_SEGW: prdata <= {16'h0, seg_q[sel_q][segi_q].endv};
          `SPG_A_CALM: prdata <= {20'h0, cm_q[sel_q]};
          `SPG_A_CALW: prdata <= {25'h0, cw_q[sel_q]};
          `SPG_A_CALD: prdata <= {1'h0, cd_q[sel_q]};
          `SPG_A_CALH: prdata <= {8'h0, ch_q[sel_q]};
          `SPG_A_CALS: prdata <= cs_q[sel_q][31:0];
          `SPG_A_CALN: prdata <= {4'h0, cs_q[sel_q][59:32]};
          `SPG_A_STAT: prdata <= cn_q[sel_q][31:0];
          `SPG_A_OUT:  prdata <= {4'h0, cn_q[sel_q][59:32]};
          `SPG_A_RUN:  prdata <= {24'h0, 8'(run_q)};
          `SPG_A_LVL:  prdata <= {16'h0, lvl_q[sel_q]};
          default:     prdata <= 32'h0;
        endcase
      end
    end
  end

  // Calendar sample: fields already on pclk
  wire cal_hit_any = cal.sec_pulse;

  genvar g;
  generate
    for (g = 0; g < NPROF; g++)
    begin : g_prof
      logic signed [15:0] src;
      logic        above_q;
      logic [SW-1:0] cur_q;
      logic [31:0] tk_q;
      logic [31:0] tot_q;
      logic [15:0] rep_q;
      logic signed [31:0] start_q;
      logic        trans_q;
      logic        cal_ok;
      logic        cal_en;
      logic        rise;
      logic        above;
      spg_pkg::spg_seg_t cs;
      assign src   = trig_src[g*16 +: 16];
      assign above = (src > 16'sh0);
      assign rise  = above && !above_q;
      assign cs    = seg_q[g][cur_q];
      assign cal_en = (cm_q[g] != '0) && (cw_q[g] != '0) && (cd_q[g] != '0) &&
                      (ch_q[g] != '0) && (cs_q[g] != '0) && (cn_q[g] != '0);
      assign cal_ok = cal_en && cal_hit_any &&
                      mask_hit(60'(cm_q[g]), 6'(cal.mon)) &&
                      mask_hit(60'(cw_q[g]), 6'(cal.wday)) &&
                      mask_hit(60'(cd_q[g]), 6'(cal.day)) &&
                      mask_hit(60'(ch_q[g]), 6'(cal.hour)) &&
                      mask_hit(cn_q[g], cal.min) &&
                      mask_hit(cs_q[g], cal.sec);
      assign tick_en[g] = tick_q;

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          above_q <= 1'b0;
          run_q[g] <= 1'b0;
          cur_q   <= '0;
          tk_q    <= 32'h0;
          tot_q   <= 32'h1;
          rep_q   <= 16'h0;
          start_q <= 32'sh0;
          trans_q <= 1'b0;
          lvl_q[g] <= 16'h0;
        end
        else
        begin
          above_q <= above;
          if (mode_q[g] == spg_pkg::SPG_OFF ||
              (mode_q[g] == spg_pkg::SPG_GATE && !above))
          begin
            run_q[g] <= 1'b0;
            cur_q    <= '0;
            lvl_q[g] <= idle_q[g];
          end
          else if ((mode_q[g] == spg_pkg::SPG_GATE && !run_q[g] && rise) ||
                   (mode_q[g] == spg_pkg::SPG_ONCE && !run_q[g] && rise) ||
                   (mode_q[g] == spg_pkg::SPG_RESTART && rise) ||
                   (mode_q[g] == spg_pkg::SPG_CAL && !run_q[g] && cal_ok))
          begin
            run_q[g] <= 1'b1;
            cur_q    <= '0;
            tk_q     <= 32'h0;
            tot_q    <= 32'(seg_q[g][0].dur) * unit_ticks(seg_q[g][0].unit);
            rep_q    <= 16'h1;
            start_q  <= 32'(signed'(idle_q[g]));
            trans_q  <= 1'b0;
          end
          else if (!run_q[g])
            lvl_q[g] <= idle_q[g];
          else if (tick_en[g])
          begin
            if (cs.slope && tot_q != 0)
              lvl_q[g] <= 16'(start_q + ((32'(signed'(cs.endv)) - start_q) *
                              signed'(tk_q + 32'h1)) / signed'(tot_q));
            else
              lvl_q[g] <= cs.endv;
            trans_q <= 1'b0;
            if (tk_q + 32'h1 >= tot_q)
            begin
              lvl_q[g] <= cs.endv;
              start_q  <= 32'(signed'(cs.endv));
              tk_q     <= 32'h0;
              if (cur_q < nseg_q[g])
              begin
                cur_q <= cur_q + 1'b1;
                tot_q <= 32'(seg_q[g][cur_q+1'b1].dur) *
                         unit_ticks(seg_q[g][cur_q+1'b1].unit);
              end
              else if (loopm_q[g] == spg_pkg::SPG_LOOP_INF ||
                       (loopm_q[g] == spg_pkg::SPG_LOOP_COUNT && rep_q < lcnt_q[g]))
              begin
                cur_q <= ret_q[g];
                rep_q <= rep_q + 16'h1;
                tot_q <= 32'(seg_q[g][ret_q[g]].dur) * unit_ticks(seg_q[g][ret_q[g]].unit);
                trans_q <= 1'b1;
              end
              else
                run_q[g] <= 1'b0;
            end
            else
              tk_q <= tk_q + 32'h1;
          end
        end
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          level_out[g*16 +: 16] <= 16'h0;
        else
          level_out[g*16 +: 16] <= lvl_q[g];
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      running <= '0;
    else
      running <= run_q;
  end
endmodule
`default_nettype wire

// >>> dv/spg_checker.sv
// Purpose: Port checks for spg_top
// Assumes: One clock, async low reset
// Notes:   Bound after endmodule
`timescale 1ns/100ps
`default_nettype none
module spg_checker #(
  parameter int NPROF = 8
) (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic [NPROF*16-1:0] level_out,
  input wire logic [NPROF-1:0]    running
);
  logic [2:0] calm_q;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  // Profile 0 idle and no bus write
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      calm_q <= 3'h0;
    else
      calm_q <= {calm_q[1:0], !running[0] && !(psel && pwrite)};
  chk_ready_after_setup:
    assert property (s_setup |=> pready) else $error("no ready after setup");
  chk_ready_one_beat:
    assert property (pready |=> !pready) else $error("ready held too long");
  chk_ready_in_access:
    assert property (pready |-> s_access) else $error("ready outside access");
  chk_no_error:
    assert property (!pslverr) else $error("error response seen");
  chk_rdata_on_read:
    assert property ($changed(prdata) |-> $past(psel && !pwrite))
    else $error("read data moved without read");
  chk_release_quiet:
    assert property ($rose(presetn) |-> running == '0 && level_out == '0)
    else $error("outputs busy after reset");
  chk_idle_level_hold:
    assert property (&calm_q |-> $stable(level_out[15:0]))
    else $error("rest level moved");
  chk_level_tick_gap:
    assert property (($changed(level_out[15:0]) && running[0] && $past(running[0], 2))
      |=> (!$changed(level_out[15:0]) || !running[0]) [*4])
    else $error("level stepped between ticks");
endmodule
bind spg_top spg_checker #(.NPROF(NPROF)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .level_out(level_out), .running(running));
`default_nettype wire

// >>> dv/spg_far_end.sv
// Purpose: Trigger channels and calendar source
// Assumes: Calendar fields fixed, pulse each second
// Notes:   Off trigger shows -1
`timescale 1ns/100ps
`default_nettype none
module spg_far_end #(
  parameter int NPROF   = 8,
  parameter int SEC_CYC = 100
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic [NPROF-1:0]    trig_on,
  output logic      [NPROF*16-1:0] trig_src,
  output spg_pkg::spg_cal_t        cal
);
  int cnt_q;
  always_comb
    for (int p = 0; p < NPROF; p++)
      trig_src[p*16 +: 16] = trig_on[p] ? 16'h0001 : 16'hffff;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cnt_q <= 0;
      cal   <= '0;
    end
    else
    begin
      cnt_q         <= (cnt_q == SEC_CYC - 1) ? 0 : cnt_q + 1;
      cal.sec_pulse <= (cnt_q == SEC_CYC - 1);
      cal.mon       <= 4'h1;
      cal.day       <= 5'h01;
    end
endmodule
`default_nettype wire

// >>> dv/spg_top_bench.sv
// Purpose: Self-checking bench for spg_top
// Assumes: Tick of 10 cycles, one second 100 cycles
// Notes:   Profile 5 uses three segments, others one
`timescale 1ns/100ps
`default_nettype none
`include "spg_consts.svh"
module spg_top_bench;
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [11:0]       paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [127:0]      trig_src;
  spg_pkg::spg_cal_t cal;
  logic [127:0]      level_out;
  logic [7:0]        running;
  logic [7:0]        trig_on;
  logic [31:0]       rd;
  logic [15:0]       pk;
  int                n;
  int                num_errors = 0;
  int                checked = 0;
  int                cyc = 0;
  spg_top #(.TICK_CYC(10)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trig_src(trig_src), .cal(cal),
    .level_out(level_out), .running(running));
  spg_far_end u_far (.pclk(pclk), .presetn(presetn), .trig_on(trig_on),
    .trig_src(trig_src), .cal(cal));
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cfg(input logic [2:0] p, input logic [2:0] m, input logic [1:0] lp,
                     input logic sl, input logic [15:0] ev);
    apb(1'b1, `SPG_A_SEL, {29'h0, p});
    apb(1'b1, `SPG_A_SEG, {11'h0, sl, 4'h0, 16'h0001});
    apb(1'b1, `SPG_A_SEGW, {16'h0, ev});
    apb(1'b1, `SPG_A_IDLE, 32'h0000_0005);
    apb(1'b1, `SPG_A_LOOP, 32'h0000_0002);
    apb(1'b1, `SPG_A_CTRL, {26'h0, lp, 1'b0, m});
    repeat (4) @(posedge pclk);
  endtask
  task automatic put_seg(input logic [3:0] s, input logic sl, input logic [15:0] ev);
    apb(1'b1, `SPG_A_SEL, {20'h0, s, 8'h05});
    apb(1'b1, `SPG_A_SEG, {11'h0, sl, 4'h0, 16'h0001});
    apb(1'b1, `SPG_A_SEGW, {16'h0, ev});
  endtask
  task automatic run_len(input int p);
    n = 0;
    pk = 16'h0;
    while (running[p] === 1'b1 && n < 5000)
    begin
      @(posedge pclk);
      n++;
      if ($signed(level_out[p*16 +: 16]) > $signed(pk))
        pk = level_out[p*16 +: 16];
    end
  endtask
  task automatic t_reset();
    check(level_out[31:0], 32'h0);
    apb(1'b0, 12'h040, 32'h0);
    check(rd, 32'h0);
  endtask
  task automatic t_gate();
    cfg(3'h0, spg_pkg::SPG_GATE, spg_pkg::SPG_LOOP_ONCE, 1'b0, 16'h0064);
    check(level_out[15:0], 16'h0005);
    apb(1'b0, `SPG_A_IDLE, 32'h0);
    check(rd, 32'h0000_0005);
    trig_on <= 8'h09;
    repeat (60) @(posedge pclk);
    check(running[0], 1'b1);
    check(running[3], 1'b0);
    apb(1'b0, `SPG_A_RUN, 32'h0);
    check(rd, 32'h0000_0001);
    trig_on <= 8'h00;
    repeat (5) @(posedge pclk);
    check(running[0], 1'b0);
    check(level_out[15:0], 16'h0005);
    trig_on <= 8'h01;
    repeat (4) @(posedge pclk);
    check(running[0], 1'b1);
    trig_on <= 8'h00;
  endtask
  task automatic t_once();
    cfg(3'h1, spg_pkg::SPG_ONCE, spg_pkg::SPG_LOOP_COUNT, 1'b1, 16'h03e8);
    trig_on <= 8'h02;
    repeat (3) @(posedge pclk);
    trig_on <= 8'h00;
    repeat (3) @(posedge pclk);
    run_len(1);
    check(n >= 180 && n <= 210, 1'b1);
    check(pk, 16'h03e8);
    repeat (3) @(posedge pclk);
    check(level_out[31:16], 16'h0005);
  endtask
  task automatic t_restart();
    cfg(3'h2, spg_pkg::SPG_RESTART, spg_pkg::SPG_LOOP_ONCE, 1'b0, 16'h0032);
    trig_on <= 8'h04;
    repeat (60) @(posedge pclk);
    trig_on <= 8'h00;
    repeat (2) @(posedge pclk);
    trig_on <= 8'h04;
    repeat (3) @(posedge pclk);
    run_len(2);
    check(n >= 85 && n <= 105, 1'b1);
    trig_on <= 8'h00;
  endtask
  task automatic t_cal();
    cfg(3'h4, spg_pkg::SPG_CAL, spg_pkg::SPG_LOOP_ONCE, 1'b0, 16'h0046);
    for (int a = 'h14; a <= 'h30; a += 4)
      apb(1'b1, a[11:0], (a == 'h14) ? 32'h0 : 32'hffff_ffff);
    repeat (250) @(posedge pclk);
    check(running[4], 1'b0);
    apb(1'b1, `SPG_A_CALM, 32'hffff_ffff);
    n = 0;
    while (running[4] !== 1'b1 && n < 250)
    begin
      @(posedge pclk);
      n++;
    end
    check(running[4], 1'b1);
    apb(1'b1, `SPG_A_CALM, 32'h0);
    repeat (20) @(posedge pclk);
    check(running[4], 1'b1);
  endtask
  task automatic t_loop();
    put_seg(4'h0, 1'b0, 16'h0010);
    put_seg(4'h1, 1'b1, 16'h0064);
    put_seg(4'h2, 1'b0, 16'h0030);
    apb(1'b1, `SPG_A_IDLE, 32'h0000_0005);
    apb(1'b1, `SPG_A_LOOP, 32'h0000_0002);
    for (int r = 1; r >= 0; r--)
    begin
      apb(1'b1, `SPG_A_CTRL, {12'h0, 4'(r), 4'h0, 4'h2, 2'h0, spg_pkg::SPG_LOOP_COUNT, 1'b0,
                              spg_pkg::SPG_ONCE});
      trig_on <= 8'h20;
      n = 0;
      while (level_out[95:80] !== 16'h0030 && n < 600)
      begin
        @(posedge pclk);
        n++;
      end
      trig_on <= 8'h00;
      n = 0;
      while (level_out[95:80] === 16'h0030 && n < 300)
      begin
        @(posedge pclk);
        n++;
      end
      check(n, 32'h64);
      if (r == 1)
        check(level_out[95:80], 16'h0035);
      else
        check(level_out[95:80], 16'h0010);
      run_len(5);
      check(n, (r == 1) ? 32'hbe : 32'h122);
      repeat (3) @(posedge pclk);
      check(level_out[95:80], 16'h0005);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      complete_run();
    end
  end
  initial
  begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    trig_on = 8'h00;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_gate();
    t_once();
    t_restart();
    t_cal();
    t_loop();
    complete_run();
  end
endmodule
`default_nettype wire
